// [cpu8_bus_pkg.sv]
// Shared types and constants for the 8-bit core external bus control block
`default_nettype none

package cpu8_bus_pkg;

  localparam logic [15:0] RESET_VEC = 16'h0000;
  localparam logic [15:0] NMI_VEC   = 16'h0066;
  localparam logic [15:0] INT_VEC   = 16'h0038;

  typedef enum logic [2:0] {
    KIND_FETCH,
    KIND_MEM_RD,
    KIND_MEM_WR,
    KIND_IO_RD,
    KIND_IO_WR
  } xfer_kind_t;

  // One machine cycle asked for by the core
  typedef struct packed {
    xfer_kind_t  kind;
    logic        last;         // Final machine cycle of the instruction
    logic        io_indirect;  // I/O address from the B:C register pair
    logic [15:0] addr;
    logic [7:0]  reg_b;
    logic [7:0]  reg_c;
    logic [7:0]  wdata;
  } xfer_req_t;

  typedef struct packed {
    logic mem_write_strobe;
    logic mem_read_strobe;
    logic io_write_strobe;
    logic io_read_strobe;
  } strobes_t;

  typedef struct packed {
    logic        nmi;
    logic        irq;
    logic [15:0] addr;
  } vector_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ACCESS,
    ST_FLOAT,
    ST_GRANT
  } bus_state_t;

  typedef struct packed {
    bus_state_t  st;
    logic        last;
    logic        taken;
    logic        stopped;
    logic        boot;
    logic        nmi_pend;
    logic        nmi_prev;
    logic        fetch;
    strobes_t    strobes;
    logic        strobe_tri_n;
    logic        data_tri_n;
    logic        addr_tri_n;
    logic        grant;
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        rsp_valid;
    logic [7:0]  rsp_data;
    logic        vec_valid;
    vector_t     vec;
    logic [15:0] ext_addr;
  } ctl_state_t;

  localparam ctl_state_t CTL_RESET = '{
    st:           ST_IDLE,
    boot:         1'b1,
    strobe_tri_n: 1'b1,
    addr_tri_n:   1'b1,
    default:      '0
  };

endpackage : cpu8_bus_pkg

`default_nettype wire

// [cpu8_bus_ctl.sv]
// External pin-level bus control of the 8-bit core: strobes, wait, interrupts, bus handover
`default_nettype none

module cpu8_bus_ctl
  import cpu8_bus_pkg::*;
(
  input  wire logic                   i_clk,               // System clock, 25 MHz
  input  wire logic                   i_arst_n,            // Asynchronous reset, active low
  input  wire logic                   i_rst,               // Reset pin, synchronous, active high
  input  wire logic                   i_hold_off_in,       // Addressed device not ready
  input  wire logic                   i_int,               // Maskable interrupt request level
  input  wire logic                   i_nmi,               // Non-maskable request, rising edge
  input  wire logic                   i_takeover,          // Outside master bus request
  input  wire logic [7:0]             i_mem_read_bus,      // Read data from memory space
  input  wire logic [7:0]             i_io_read_bus,       // Read data from I/O space
  input  wire logic [15:0]            i_ext_addr,          // Address from outside master
  input  wire logic                   i_req_valid,         // Core asks for a machine cycle
  input  wire cpu8_bus_pkg::xfer_req_t i_req,              // Machine cycle description
  input  wire logic                   i_int_enable,        // Core interrupt enable flip-flop
  input  wire logic                   i_halt_exec,         // Core executed a halt, pulse
  output logic                        o_stopped_flag,      // Halted, awaiting interrupt
  output logic                        o_opcode_fetch_flag, // Opcode fetch cycle
  output cpu8_bus_pkg::strobes_t      o_strobes,           // Memory and I/O strobes
  output logic                        o_strobe_tri_n,      // Low floats the strobes
  output logic                        o_data_tri_n,        // Low floats the write bus
  output logic                        o_addr_tri_n,        // Low floats the address bus
  output logic                        o_bus_grant,         // Buses handed to outside master
  output logic [15:0]                 o_addr,              // Address bus
  output logic [7:0]                  o_write_bus_out,     // Write data bus
  output logic                        o_req_taken,         // Request accepted, pulse
  output logic                        o_rsp_valid,         // Machine cycle done, pulse
  output logic [7:0]                  o_rsp_data,          // Read data of the cycle
  output logic                        o_vec_valid,         // Restart address valid, pulse
  output cpu8_bus_pkg::vector_t       o_vec,               // Restart address and cause
  output logic [15:0]                 o_ext_addr           // Address seen while granted
);

  import cpu8_bus_pkg::*;

  ctl_state_t q;
  ctl_state_t d;
  logic       nmi_seen;
  logic       instr_end;
  logic       take_req;

  function automatic strobes_t strobes_of(input xfer_kind_t kind);
    strobes_t s;
    s = '0;
    s.mem_read_strobe  = (kind == KIND_FETCH) || (kind == KIND_MEM_RD);
    s.mem_write_strobe = (kind == KIND_MEM_WR);
    s.io_read_strobe   = (kind == KIND_IO_RD);
    s.io_write_strobe  = (kind == KIND_IO_WR);
    return s;
  endfunction : strobes_of

  function automatic logic [15:0] bus_addr(input xfer_req_t r);
    logic is_io;
    is_io = (r.kind == KIND_IO_RD) || (r.kind == KIND_IO_WR);
    if (is_io && r.io_indirect)
    begin
      return {r.reg_b, r.reg_c};
    end
    return r.addr;
  endfunction : bus_addr

  always_comb
  begin
    d           = q;
    d.taken     = 1'b0;
    d.rsp_valid = 1'b0;
    d.vec_valid = 1'b0;
    d.nmi_prev  = i_nmi;
    // A pending edge waits for an instruction end; an edge in the taking cycle is that same request
    nmi_seen    = q.nmi_pend || (i_nmi && !q.nmi_prev);
    d.nmi_pend  = nmi_seen;
    instr_end   = 1'b0;
    take_req    = 1'b0;
    if (i_rst)
    begin
      d = CTL_RESET;
    end
    else
    begin
      if (i_halt_exec)
      begin
        d.stopped = 1'b1;
      end
      case (q.st)
        ST_IDLE:
        begin
          if (i_takeover)
          begin
            // Float first; grant follows a cycle later so no two drivers overlap
            d.st           = ST_FLOAT;
            d.strobe_tri_n = 1'b0;
            d.addr_tri_n   = 1'b0;
            d.data_tri_n   = 1'b0;
          end
          else if (q.boot)
          begin
            d.boot      = 1'b0;
            d.vec_valid = 1'b1;
            d.vec       = '{nmi: 1'b0, irq: 1'b0, addr: RESET_VEC};
          end
          else if (q.stopped)
          begin
            instr_end = 1'b1;
          end
          else if (i_req_valid)
          begin
            take_req     = 1'b1;
            d.st         = ST_ACCESS;
            d.taken      = 1'b1;
            d.last       = i_req.last;
            d.addr       = bus_addr(i_req);
            d.wdata      = i_req.wdata;
            d.strobes    = strobes_of(i_req.kind);
            d.fetch      = (i_req.kind == KIND_FETCH);
            d.data_tri_n = (i_req.kind == KIND_MEM_WR) || (i_req.kind == KIND_IO_WR);
          end
        end
        ST_ACCESS:
        begin
          // Same-clock device: hold-off is sampled at every edge of the access
          if (!i_hold_off_in)
          begin
            d.st         = ST_IDLE;
            d.strobes    = '0;
            d.fetch      = 1'b0;
            d.data_tri_n = 1'b0;
            d.rsp_valid  = 1'b1;
            d.rsp_data   = q.strobes.io_read_strobe ? i_io_read_bus : i_mem_read_bus;
            instr_end    = q.last;
          end
        end
        ST_FLOAT:
        begin
          d.st    = ST_GRANT;
          d.grant = 1'b1;
        end
        ST_GRANT:
        begin
          // Address bus is an input now: capture what the outside master drives
          d.ext_addr = i_ext_addr;
          if (!i_takeover)
          begin
            d.st           = ST_IDLE;
            d.grant        = 1'b0;
            d.strobe_tri_n = 1'b1;
            d.addr_tri_n   = 1'b1;
          end
        end
        default:
        begin
          d = CTL_RESET;
        end
      endcase
      if (instr_end)
      begin
        if (nmi_seen)
        begin
          d.nmi_pend  = 1'b0;
          d.stopped   = 1'b0;
          d.vec_valid = 1'b1;
          d.vec       = '{nmi: 1'b1, irq: 1'b0, addr: NMI_VEC};
        end
        else if (i_int && i_int_enable)
        begin
          d.stopped   = 1'b0;
          d.vec_valid = 1'b1;
          d.vec       = '{nmi: 1'b0, irq: 1'b1, addr: INT_VEC};
        end
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      q <= CTL_RESET;
    end
    else
    begin
      q <= d;
    end
  end

  assign o_stopped_flag      = q.stopped;
  assign o_opcode_fetch_flag = q.fetch;
  assign o_strobes           = q.strobes;
  assign o_strobe_tri_n      = q.strobe_tri_n;
  assign o_data_tri_n        = q.data_tri_n;
  assign o_addr_tri_n        = q.addr_tri_n;
  assign o_bus_grant         = q.grant;
  assign o_addr              = q.addr;
  assign o_write_bus_out     = q.wdata;
  assign o_req_taken         = q.taken;
  assign o_rsp_valid         = q.rsp_valid;
  assign o_rsp_data          = q.rsp_data;
  assign o_vec_valid         = q.vec_valid;
  assign o_vec               = q.vec;
  assign o_ext_addr          = q.ext_addr;

  // Checks sample on the system clock and sleep through either reset
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_arst_n || i_rst);

  fetch_with_read_a: assert property (o_opcode_fetch_flag |-> o_strobes.mem_read_strobe)
    else $error("fetch flag without memory read strobe");
  fetch_two_edges_a: assert property ($rose(o_opcode_fetch_flag) && !i_hold_off_in
    |=> !o_opcode_fetch_flag)
    else $error("fetch flag not dropped at second edge");
  wait_stretch_a: assert property (q.st == ST_ACCESS && i_hold_off_in
    |=> q.st == ST_ACCESS && $stable(o_strobes))
    else $error("access ended while hold-off high");
  write_data_stable_a: assert property (o_strobes.mem_write_strobe && $past(o_strobes.mem_write_strobe)
    |-> $stable(o_write_bus_out) && o_data_tri_n)
    else $error("write data moved during memory write");
  io_read_mux_a: assert property (q.st == ST_ACCESS && q.strobes.io_read_strobe && !i_hold_off_in
    |=> o_rsp_valid && o_rsp_data == $past(i_io_read_bus))
    else $error("I/O read data not from I/O bus");
  mem_read_mux_a: assert property (q.st == ST_ACCESS && q.strobes.mem_read_strobe && !i_hold_off_in
    |=> o_rsp_valid && o_rsp_data == $past(i_mem_read_bus))
    else $error("memory read data not from memory bus");
  indirect_io_addr_a: assert property (take_req && i_req.io_indirect
    && (i_req.kind == KIND_IO_RD || i_req.kind == KIND_IO_WR)
    |=> o_addr[15:8] == $past(i_req.reg_b) && o_addr[7:0] == $past(i_req.reg_c))
    else $error("indirect I/O address not B:C");
  nmi_vector_a: assert property (o_vec_valid && o_vec.nmi |-> o_vec.addr == NMI_VEC && !o_vec.irq)
    else $error("NMI vector wrong");
  int_gated_a: assert property (o_vec_valid && o_vec.irq
    |-> $past(i_int_enable) && $past(i_int) && !$past(nmi_seen) && o_vec.addr == INT_VEC)
    else $error("maskable interrupt taken while disabled or behind NMI");
  halt_stop_a: assert property ($rose(o_stopped_flag) |-> $past(i_halt_exec))
    else $error("stopped flag rose without halt");
  takeover_grant_a: assert property (q.st == ST_IDLE && i_takeover |=> ##1 o_bus_grant)
    else $error("takeover not granted at cycle boundary");
  grant_floated_a: assert property (o_bus_grant
    |-> !o_addr_tri_n && !o_data_tri_n && !o_strobe_tri_n && o_strobes == '0)
    else $error("grant while buses still driven");
  grant_release_a: assert property (o_bus_grant && !i_takeover |=> !o_bus_grant && o_addr_tri_n)
    else $error("grant held after release");
  boot_vector_a: assert property (o_vec_valid && !o_vec.nmi && !o_vec.irq |-> o_vec.addr == RESET_VEC)
    else $error("reset vector not zero");

  // Strobe, interrupt and handover checks
  io_write_hold_a: assert property (o_strobes.io_write_strobe && $past(o_strobes.io_write_strobe)
    |-> $stable(o_write_bus_out) && o_data_tri_n)
    else $error("write data moved during I/O write");
  data_float_a: assert property (!o_strobes.mem_write_strobe && !o_strobes.io_write_strobe
    |-> !o_data_tri_n)
    else $error("write bus driven outside a write");
  io_read_kind_a: assert property (take_req && i_req.kind == KIND_IO_RD
    |=> o_strobes.io_read_strobe && !o_strobes.mem_read_strobe && !o_opcode_fetch_flag)
    else $error("I/O read without its own strobe");
  mem_read_kind_a: assert property (take_req && i_req.kind == KIND_MEM_RD
    |=> o_strobes.mem_read_strobe && !o_opcode_fetch_flag)
    else $error("data read marked as fetch or not strobed");
  access_driven_a: assert property (q.st == ST_ACCESS
    |-> o_addr_tri_n && o_strobe_tri_n && !o_bus_grant)
    else $error("address or strobes floated during an access");
  access_before_float_a: assert property (q.st == ST_ACCESS && i_takeover
    |=> o_addr_tri_n && o_strobe_tri_n)
    else $error("buses floated before the machine cycle ended");
  takeover_first_a: assert property (q.st == ST_IDLE && i_takeover
    |=> q.st == ST_FLOAT && !o_vec_valid && !o_req_taken)
    else $error("takeover lost to a request or vector");
  float_before_grant_a: assert property (q.st == ST_FLOAT
    |-> !o_strobe_tri_n && !o_addr_tri_n && !o_data_tri_n && !o_bus_grant)
    else $error("grant before the buses floated");
  ext_addr_follow_a: assert property (q.st == ST_GRANT |=> o_ext_addr == $past(i_ext_addr))
    else $error("outside master address not captured");
  strobes_onehot_a: assert property ($onehot0(o_strobes))
    else $error("more than one strobe high");
  stop_holds_a: assert property (o_stopped_flag && !nmi_seen && !(i_int && i_int_enable)
    |=> o_stopped_flag)
    else $error("stopped flag dropped without interrupt");
  nmi_priority_a: assert property (instr_end && nmi_seen |=> o_vec_valid && o_vec.nmi && !o_vec.irq)
    else $error("pending NMI not taken at instruction end");
  int_taken_a: assert property (instr_end && !nmi_seen && i_int && i_int_enable
    |=> o_vec_valid && o_vec.irq && o_vec.addr == INT_VEC)
    else $error("enabled maskable interrupt not taken");
  mid_instr_a: assert property (o_rsp_valid && !q.last |-> !o_vec_valid)
    else $error("interrupt taken inside an instruction");

  fetch_done_c: cover property ($rose(o_opcode_fetch_flag) ##1 o_rsp_valid);
  wait_used_c: cover property (q.st == ST_ACCESS && i_hold_off_in ##1 q.st == ST_ACCESS ##1 o_rsp_valid);
  grant_cycle_c: cover property (o_bus_grant ##1 !o_bus_grant);
  nmi_from_halt_c: cover property (o_stopped_flag ##1 o_vec_valid && o_vec.nmi);
  irq_vector_c: cover property (o_vec_valid && o_vec.irq);

endmodule : cpu8_bus_ctl

`default_nettype wire

// [cpu8_far_side.sv]
// Behavioural model of memory, I/O space and the outside bus master
`default_nettype none

module cpu8_far_side
(
  input  wire logic                    i_clk,       // System clock
  input  wire logic                    i_arst_n,    // Reset, active low
  input  wire cpu8_bus_pkg::strobes_t  i_strobes,   // Strobes from the block
  input  wire logic [15:0]             i_addr,      // Address bus
  input  wire logic                    i_bus_grant, // Grant from the block
  input  wire logic [3:0]              i_wait_cnt,  // Wait cycles per access
  input  wire logic                    i_want_bus,  // Master wants the bus
  output logic                         o_hold_off,  // Not ready
  output logic [7:0]                   o_mem_data,  // Memory read data
  output logic [7:0]                   o_io_data,   // I/O read data
  output logic                         o_takeover,  // Bus request
  output logic [15:0]                  o_ext_addr   // Address from master
);
  timeunit 1ns;
  timeprecision 1ps;
  import cpu8_bus_pkg::*;

  logic [3:0]  cnt_q;
  logic [15:0] junk_q;
  logic        drive_q;
  logic        any_strobe;

  assign any_strobe = |i_strobes;
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      cnt_q      <= 4'h0;
      junk_q     <= 16'h0000;
      drive_q    <= 1'b0;
      o_takeover <= 1'b0;
    end
    else
    begin
      cnt_q      <= any_strobe ? cnt_q + 4'h1 : 4'h0;
      junk_q     <= junk_q + 16'h3B5D;
      drive_q    <= i_want_bus & i_bus_grant;
      o_takeover <= i_want_bus | drive_q;
    end
  end
  // A slow device stays not ready for the first i_wait_cnt edges of each access
  assign o_hold_off = any_strobe && (cnt_q < i_wait_cnt);
  // Released lines show a changing pattern so stale data never passes
  assign o_mem_data = i_strobes.mem_read_strobe ? i_addr[7:0] ^ 8'h5A : junk_q[7:0];
  assign o_io_data  = i_strobes.io_read_strobe ? i_addr[15:8] ^ i_addr[7:0] : junk_q[15:8];
  assign o_ext_addr = drive_q ? 16'hA5C3 : junk_q;
endmodule : cpu8_far_side

`default_nettype wire

// [tb_top.sv]
// Self-checking testbench of the external bus control block
`default_nettype none

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import cpu8_bus_pkg::*;

  logic clk = 1'b0, arst_n = 1'b0, rst = 1'b0, int_req = 1'b0, nmi = 1'b0, valid = 1'b0;
  logic int_en = 1'b0, halt = 1'b0, want_bus = 1'b0, take_mid = 1'b0, hold, tko, stopped, fetch;
  logic strobe_tri_n, data_tri_n, addr_tri_n, grant, taken, rsp_valid, vec_valid;
  logic [3:0] wait_cnt = 4'h0;
  logic [7:0] mem_data, io_data, wbus, rsp_data;
  logic [15:0] ext_in, addr, ext_out;
  xfer_req_t req = '0;
  strobes_t strobes;
  vector_t vec;
  int mismatches = 0, compares = 0, cyc = 0;

  always #20 clk = ~clk;

  cpu8_bus_ctl i_cpu8_bus_ctl (.i_clk(clk), .i_arst_n(arst_n), .i_rst(rst), .i_hold_off_in(hold),
    .i_int(int_req), .i_nmi(nmi), .i_takeover(tko), .i_mem_read_bus(mem_data), .i_io_read_bus(io_data),
    .i_ext_addr(ext_in), .i_req_valid(valid), .i_req(req), .i_int_enable(int_en), .i_halt_exec(halt),
    .o_stopped_flag(stopped), .o_opcode_fetch_flag(fetch), .o_strobes(strobes), .o_strobe_tri_n(strobe_tri_n),
    .o_data_tri_n(data_tri_n), .o_addr_tri_n(addr_tri_n), .o_bus_grant(grant), .o_addr(addr),
    .o_write_bus_out(wbus), .o_req_taken(taken), .o_rsp_valid(rsp_valid), .o_rsp_data(rsp_data),
    .o_vec_valid(vec_valid), .o_vec(vec), .o_ext_addr(ext_out));

  cpu8_far_side i_cpu8_far_side (.i_clk(clk), .i_arst_n(arst_n), .i_strobes(strobes), .i_addr(addr),
    .i_bus_grant(grant), .i_wait_cnt(wait_cnt), .i_want_bus(want_bus), .o_hold_off(hold),
    .o_mem_data(mem_data), .o_io_data(io_data), .o_takeover(tko), .o_ext_addr(ext_in));

  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : end_of_test

  always @(posedge clk)
  begin
    cyc = cyc + 1;
    if (cyc == 3000)
    begin
      mismatches = mismatches + 1;
      end_of_test();
    end
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    compares = compares + 1;
    if (seen !== exp)
    begin
      mismatches = mismatches + 1;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic tick_until(ref logic sig, output int n);
    n = 0;
    do
    begin
      @(posedge clk);
      #1;
      n = n + 1;
    end
    while (sig !== 1'b1 && n < 20);
  endtask : tick_until

  // Leaves the caller in the cycle where the response pulse stands
  task automatic bus_cycle(input xfer_kind_t k, input logic lst, input logic ind, input logic [15:0] a,
                           input logic [3:0] w);
    xfer_req_t r;
    strobes_t es;
    logic [15:0] ea;
    int n;
    r = '0;
    r.kind = k;
    r.last = lst;
    r.io_indirect = ind;
    r.addr = a;
    r.reg_b = 8'h12;
    r.reg_c = 8'hC4;
    r.wdata = a[15:8] ^ 8'hFF;
    ea = ind ? {r.reg_b, r.reg_c} : a;
    es = '0;
    es.mem_read_strobe = (k == KIND_FETCH) || (k == KIND_MEM_RD);
    es.mem_write_strobe = (k == KIND_MEM_WR);
    es.io_read_strobe = (k == KIND_IO_RD);
    es.io_write_strobe = (k == KIND_IO_WR);
    @(negedge clk);
    wait_cnt = w;
    req = r;
    valid = 1'b1;
    tick_until(taken, n);
    chk(16'(n), 16'h0001);
    chk(16'(strobes), 16'(es));
    chk(16'(fetch), 16'(k == KIND_FETCH));
    chk(addr, ea);
    chk(16'(data_tri_n), 16'(es.mem_write_strobe | es.io_write_strobe));
    if (es.mem_write_strobe | es.io_write_strobe)
      chk(16'(wbus), 16'(r.wdata));
    @(negedge clk);
    valid = 1'b0;
    want_bus = take_mid;
    tick_until(rsp_valid, n);
    chk(16'(n), 16'(w) + 16'h0001);
    if (es.mem_read_strobe)
      chk(16'(rsp_data), 16'(ea[7:0] ^ 8'h5A));
    if (es.io_read_strobe)
      chk(16'(rsp_data), 16'(ea[15:8] ^ ea[7:0]));
    chk(16'({strobes, fetch}), 16'h0000);
  endtask : bus_cycle

  task automatic test_reset();
    repeat (4) @(posedge clk);
    #1;
    chk(16'({strobe_tri_n, addr_tri_n, grant, strobes}), 16'h0060);
    @(negedge clk);
    arst_n = 1'b1;
    @(posedge clk);
    #1;
    chk(16'(vec_valid), 16'h0001);
    chk(vec.addr, RESET_VEC);
    $display("test_reset done");
  endtask : test_reset

  task automatic test_kinds();
    for (int i = 0; i < 5; i++)
      bus_cycle(xfer_kind_t'(i), 1'b0, i == 3, 16'h1000 * 16'(i) + 16'h00F3, 4'(i % 3));
    $display("test_kinds done");
  endtask : test_kinds

  task automatic test_irq();
    int n;
    @(negedge clk);
    halt = 1'b1;
    @(negedge clk);
    halt = 1'b0;
    int_req = 1'b1;
    repeat (4) @(negedge clk);
    chk(16'({stopped, vec_valid}), 16'h0002);
    int_en = 1'b1;
    tick_until(vec_valid, n);
    chk(vec.addr, INT_VEC);
    chk(16'(stopped), 16'h0000);
    @(negedge clk);
    nmi = 1'b1;
    bus_cycle(KIND_FETCH, 1'b0, 1'b0, 16'h0200, 4'h0);
    chk(16'(vec_valid), 16'h0000);
    bus_cycle(KIND_MEM_RD, 1'b1, 1'b0, 16'h0201, 4'h1);
    chk(16'({vec_valid, vec.nmi}), 16'h0003);
    chk(vec.addr, NMI_VEC);
    bus_cycle(KIND_FETCH, 1'b1, 1'b0, 16'h0066, 4'h0);
    chk(16'({vec_valid, vec.nmi, vec.irq}), 16'h0005);
    @(negedge clk);
    nmi = 1'b0;
    int_req = 1'b0;
    $display("test_irq done");
  endtask : test_irq

  task automatic test_takeover();
    int n;
    take_mid = 1'b1;
    bus_cycle(KIND_MEM_WR, 1'b0, 1'b0, 16'h3456, 4'h2);
    take_mid = 1'b0;
    tick_until(grant, n);
    chk(16'({strobe_tri_n, addr_tri_n, data_tri_n}), 16'h0000);
    repeat (3) @(posedge clk);
    #1;
    chk(ext_out, 16'hA5C3);
    @(negedge clk);
    want_bus = 1'b0;
    n = 0;
    while (grant === 1'b1 && n < 10)
    begin
      @(posedge clk);
      #1;
      n = n + 1;
    end
    chk(16'({grant, strobe_tri_n, addr_tri_n}), 16'h0003);
    bus_cycle(KIND_IO_WR, 1'b0, 1'b1, 16'h0000, 4'h0);
    $display("test_takeover done");
  endtask : test_takeover

  task automatic test_sync_reset();
    @(negedge clk);
    halt = 1'b1;
    @(negedge clk);
    halt = 1'b0;
    rst = 1'b1;
    @(negedge clk);
    rst = 1'b0;
    @(posedge clk);
    #1;
    chk(16'({stopped, vec_valid}), 16'h0001);
    chk(vec.addr, RESET_VEC);
    $display("test_sync_reset done");
  endtask : test_sync_reset

  initial
  begin
    test_reset();
    test_kinds();
    test_irq();
    test_takeover();
    test_sync_reset();
    end_of_test();
  end
endmodule : tb_top

`default_nettype wire
